// file: verilog/scs_top.sv
// System calibration sequencer with register port and ready line.
`timescale 1ns/100ps
`include "scs_params.svh"
module scs_top #(
	parameter int MOD_DIV = `SCS_MOD_TICK_MCLK,
	parameter int CAL_PERIODS = `SCS_CAL_PERIODS,
	parameter int CONV_PERIODS = `SCS_CONV_PERIODS
) (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire scs_pkg::scs_bus_req_t bus_req,
	output logic [31:0]               rd_data,
	input  wire scs_pkg::scs_sample_t sample_in,
	output logic [2:0]                gain_sel,
	output logic                      bipolar,
	output logic                      data_ready_n,
	output logic                      irq
);
	scs_pkg::scs_state_t state;
	scs_pkg::scs_state_t next_state;
	scs_pkg::scs_mode_t  cal_mode;
	scs_pkg::scs_mode_t  next_cal_mode;
	logic [2:0]  period_cnt;
	logic [2:0]  next_period_cnt;
	logic [15:0] rate_div;
	logic [15:0] next_rate_div;
	logic [31:0] zs_coef;
	logic [31:0] next_zs_coef;
	logic [31:0] fs_coef;
	logic [31:0] next_fs_coef;
	logic [31:0] data_word;
	logic [31:0] next_data_word;
	logic [2:0]  next_gain_sel;
	logic        next_bipolar;
	logic        next_data_ready_n;
	logic [31:0] next_rd_data;
	logic        mod_tick;
	logic        period_tick;
	logic        restart;
	logic        cal_cmd;
	logic        cal_done;
	logic        data_new;
	logic        stat_rd;
	logic [2:0]  irq_status;
	logic [2:0]  irq_mask;
	logic [2:0]  irq_events;

	//------------------------------------------------------------
	// Command decode
	//------------------------------------------------------------
	function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
		hit = (a == r);
	endfunction

	logic       wr_ctrl;
	logic [1:0] wr_mode;
	logic       wr_filter;
	logic       wr_mask;
	logic       rd_word;
	logic       cmd_ignored;

	assign wr_ctrl = bus_req.wr && hit(bus_req.addr, `SCS_ADDR_CTRL);
	assign wr_filter = bus_req.wr && hit(bus_req.addr, `SCS_ADDR_FILTER);
	assign wr_mask = bus_req.wr && hit(bus_req.addr, `SCS_ADDR_IRQ_MASK);
	assign rd_word = bus_req.rd && hit(bus_req.addr, `SCS_ADDR_DATA);
	assign wr_mode = {bus_req.wdata[`SCS_CTRL_MODE_HI],
		bus_req.wdata[`SCS_CTRL_MODE_LO]};

	assign cal_cmd = wr_ctrl && wr_mode[1]
		&& (state == scs_pkg::SCS_ST_IDLE);
	// A step command outside idle is dropped and reported.
	assign cmd_ignored = wr_ctrl && wr_mode[1] && !cal_cmd;
	assign stat_rd = bus_req.rd && hit(bus_req.addr, `SCS_ADDR_IRQ_STAT);

	//------------------------------------------------------------
	// Period timer
	//------------------------------------------------------------
	// restart the period timer at each accepted step command.
	assign restart = cal_cmd;

	scs_tick_gen #(
		.MOD_DIV (MOD_DIV)
	) u_tick (
		.clk         (clk),
		.rst_n       (rst_n),
		.restart     (restart),
		.rate_div    (rate_div),
		.mod_tick    (mod_tick),
		.period_tick (period_tick)
	);

	//------------------------------------------------------------
	// Sequencer
	//------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_cal_mode = cal_mode;
		next_period_cnt = period_cnt;
		next_data_word = data_word;
		next_data_ready_n = data_ready_n;
		cal_done = 1'b0;
		data_new = 1'b0;
		// Clearing on a data read lets the next word pull the line low.
		if (rd_word)
			next_data_ready_n = 1'b1;
		case (state)
			scs_pkg::SCS_ST_IDLE: begin
				if (cal_cmd) begin
					next_cal_mode = scs_pkg::scs_mode_t'(wr_mode);
					next_period_cnt = 3'h0;
					// a low line waits for the modulator tick.
					if (data_ready_n)
						next_state = scs_pkg::SCS_ST_CAL;
					else
						next_state = scs_pkg::SCS_ST_SYNC;
				end else if (sample_in.valid) begin
					next_data_word = sample_in.sample;
					next_data_ready_n = 1'b0;
					data_new = 1'b1;
				end
			end
			scs_pkg::SCS_ST_SYNC: begin
				// rise at the next modulator tick.
				if (mod_tick) begin
					next_data_ready_n = 1'b1;
					next_state = scs_pkg::SCS_ST_CAL;
				end
				if (period_tick)
					next_period_cnt = period_cnt + 3'h1;
			end
			scs_pkg::SCS_ST_CAL: begin
				// held high while the step runs.
				next_data_ready_n = 1'b1;
				if (period_tick) begin
					next_period_cnt = period_cnt + 3'h1;
					if (period_cnt == 3'(CAL_PERIODS - 1)) begin
						next_cal_mode = scs_pkg::SCS_MODE_NORMAL;
						cal_done = 1'b1;
						next_state = scs_pkg::SCS_ST_CONV;
					end
				end
			end
			scs_pkg::SCS_ST_CONV: begin
				next_data_ready_n = 1'b1;
				// one normal conversion, ready falls at period four.
				if (period_tick) begin
					next_period_cnt = period_cnt + 3'h1;
					if (period_cnt == 3'(CAL_PERIODS + CONV_PERIODS - 1)) begin
						next_data_word = sample_in.sample;
						next_data_ready_n = 1'b0;
						data_new = 1'b1;
						next_state = scs_pkg::SCS_ST_IDLE;
					end
				end
			end
			default: next_state = scs_pkg::SCS_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= scs_pkg::SCS_ST_IDLE;
			cal_mode <= scs_pkg::SCS_MODE_NORMAL;
			period_cnt <= 3'h0;
			data_word <= 32'h0000_0000;
			data_ready_n <= 1'b1;
		end else begin
			state <= next_state;
			cal_mode <= next_cal_mode;
			period_cnt <= next_period_cnt;
			data_word <= next_data_word;
			data_ready_n <= next_data_ready_n;
		end
	end

	//------------------------------------------------------------
	// Coefficient store
	//------------------------------------------------------------
	// only the running step's coefficient is loaded.
	// span limits belong to the analog front end; results stay raw.
	always_comb begin
		next_zs_coef = zs_coef;
		next_fs_coef = fs_coef;
		if (cal_done) begin
			if (cal_mode == scs_pkg::SCS_MODE_ZS_SYS)
				next_zs_coef = sample_in.sample;
			else
				next_fs_coef = sample_in.sample;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			zs_coef <= `SCS_ZS_COEF_RESET;
			fs_coef <= `SCS_FS_COEF_RESET;
		end else begin
			zs_coef <= next_zs_coef;
			fs_coef <= next_fs_coef;
		end
	end

	//------------------------------------------------------------
	// Configuration
	//------------------------------------------------------------
	// gain and polarity stay fixed across the step.
	always_comb begin
		next_gain_sel = gain_sel;
		next_bipolar = bipolar;
		next_rate_div = rate_div;
		if (wr_ctrl && state == scs_pkg::SCS_ST_IDLE) begin
			next_gain_sel = bus_req.wdata[`SCS_CTRL_GAIN_LSB +: 3];
			next_bipolar = bus_req.wdata[`SCS_CTRL_BIPOLAR];
		end
		if (wr_filter && bus_req.wdata[15:0] != 16'h0000)
			next_rate_div = bus_req.wdata[15:0];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gain_sel <= 3'h0;
			bipolar <= 1'b0;
			rate_div <= `SCS_FILTER_RESET;
		end else begin
			gain_sel <= next_gain_sel;
			bipolar <= next_bipolar;
			rate_div <= next_rate_div;
		end
	end

	//------------------------------------------------------------
	// Interrupts
	//------------------------------------------------------------
	assign irq_events = {cmd_ignored, data_new, cal_done};

	scs_irq #(
		.N (3)
	) u_irq (
		.clk        (clk),
		.rst_n      (rst_n),
		.event_in   (irq_events),
		.stat_rd    (stat_rd),
		.mask_wr    (wr_mask),
		.mask_wdata (bus_req.wdata[2:0]),
		.status     (irq_status),
		.mask       (irq_mask),
		.irq        (irq)
	);

	//------------------------------------------------------------
	// Read port
	//------------------------------------------------------------
	// Read data stands one cycle after the strobe and is zero otherwise.
	always_comb begin
		next_rd_data = 32'h0000_0000;
		if (!bus_req.rd)
			next_rd_data = 32'h0000_0000;
		else if (hit(bus_req.addr, `SCS_ADDR_CTRL))
			next_rd_data = {25'h0, gain_sel, 1'b0, bipolar, cal_mode};
		else if (hit(bus_req.addr, `SCS_ADDR_FILTER))
			next_rd_data = {16'h0000, rate_div};
		else if (hit(bus_req.addr, `SCS_ADDR_STATUS))
			next_rd_data = {27'h0, period_cnt, state};
		else if (hit(bus_req.addr, `SCS_ADDR_IRQ_STAT))
			next_rd_data = {29'h0, irq_status};
		else if (hit(bus_req.addr, `SCS_ADDR_IRQ_MASK))
			next_rd_data = {29'h0, irq_mask};
		else if (hit(bus_req.addr, `SCS_ADDR_ZS_COEF))
			next_rd_data = zs_coef;
		else if (hit(bus_req.addr, `SCS_ADDR_FS_COEF))
			next_rd_data = fs_coef;
		else if (hit(bus_req.addr, `SCS_ADDR_DATA))
			next_rd_data = data_word;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			rd_data <= 32'h0000_0000;
		else
			rd_data <= next_rd_data;
	end
endmodule

// file: shared/scs_params.svh
// Constants for the system calibration sequencer.
`ifndef SCS_PARAMS_SVH
`define SCS_PARAMS_SVH
`define SCS_ADDR_CTRL        4'h0
`define SCS_ADDR_FILTER      4'h1
`define SCS_ADDR_STATUS      4'h2
`define SCS_ADDR_IRQ_STAT    4'h3
`define SCS_ADDR_IRQ_MASK    4'h4
`define SCS_ADDR_ZS_COEF     4'h5
`define SCS_ADDR_FS_COEF     4'h6
`define SCS_ADDR_DATA        4'h7
`define SCS_CTRL_MODE_LO     0
`define SCS_CTRL_MODE_HI     1
`define SCS_CTRL_BIPOLAR     2
`define SCS_CTRL_GAIN_LSB    4
`define SCS_MOD_TICK_MCLK    128
`define SCS_CAL_PERIODS      3
`define SCS_CONV_PERIODS     1
`define SCS_FILTER_RESET     16'h0004
`define SCS_ZS_COEF_RESET    32'h0000_0000
`define SCS_FS_COEF_RESET    32'h0080_0000
`define SCS_IRQ_CAL_DONE     0
`define SCS_IRQ_DATA_NEW     1
`define SCS_IRQ_IGNORED      2
`define SCS_MIN_SPAN_X100    210'd0
`endif

// file: shared/scs_pkg.sv
// Types shared by the system calibration sequencer files.
package scs_pkg;
	typedef enum logic [1:0] {
		SCS_MODE_NORMAL = 2'b00,
		SCS_MODE_SELF   = 2'b01,
		SCS_MODE_ZS_SYS = 2'b10,
		SCS_MODE_FS_SYS = 2'b11
	} scs_mode_t;

	typedef enum logic [1:0] {
		SCS_ST_IDLE = 2'b00,
		SCS_ST_SYNC = 2'b01,
		SCS_ST_CAL  = 2'b10,
		SCS_ST_CONV = 2'b11
	} scs_state_t;

	typedef struct packed {
		logic [3:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} scs_bus_req_t;

	typedef struct packed {
		logic [31:0] sample;
		logic        valid;
	} scs_sample_t;
endpackage

// file: verilog/scs_tick_gen.sv
// Modulator tick and output-rate period strobes.
`timescale 1ns/100ps
`include "scs_params.svh"
module scs_tick_gen #(
	parameter int MOD_DIV = `SCS_MOD_TICK_MCLK
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        restart,
	input  wire logic [15:0] rate_div,
	output logic             mod_tick,
	output logic             period_tick
);
	logic [7:0]  mod_cnt;
	logic [7:0]  next_mod_cnt;
	logic [15:0] per_cnt;
	logic [15:0] next_per_cnt;
	logic        next_mod_tick;
	logic        next_period_tick;

	// Output-rate periods are whole numbers of modulator ticks.
	always_comb begin
		next_mod_cnt = mod_cnt + 8'h01;
		next_per_cnt = per_cnt;
		next_mod_tick = 1'b0;
		next_period_tick = 1'b0;
		if (restart) begin
			next_mod_cnt = 8'h00;
			next_per_cnt = 16'h0000;
		end else if (mod_cnt == 8'(MOD_DIV - 1)) begin
			next_mod_cnt = 8'h00;
			next_mod_tick = 1'b1;
			if (per_cnt >= rate_div - 16'h0001) begin
				next_per_cnt = 16'h0000;
				next_period_tick = 1'b1;
			end else begin
				next_per_cnt = per_cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mod_cnt <= 8'h00;
			per_cnt <= 16'h0000;
			mod_tick <= 1'b0;
			period_tick <= 1'b0;
		end else begin
			mod_cnt <= next_mod_cnt;
			per_cnt <= next_per_cnt;
			mod_tick <= next_mod_tick;
			period_tick <= next_period_tick;
		end
	end
endmodule

// file: verilog/scs_irq.sv
// Sticky event status, mask and interrupt output.
`timescale 1ns/100ps
module scs_irq #(
	parameter int N = 3
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [N-1:0] event_in,
	input  wire logic         stat_rd,
	input  wire logic         mask_wr,
	input  wire logic [N-1:0] mask_wdata,
	output logic      [N-1:0] status,
	output logic      [N-1:0] mask,
	output logic              irq
);
	logic [N-1:0] next_status;
	logic [N-1:0] next_mask;

	// A new event in the clearing read's cycle stays set.
	always_comb begin
		next_status = (stat_rd ? {N{1'b0}} : status) | event_in;
		next_mask = mask_wr ? mask_wdata : mask;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			status <= '0;
			mask <= '0;
		end else begin
			status <= next_status;
			mask <= next_mask;
		end
	end

	assign irq = |(status & mask);
endmodule

// file: tb/scs_top_sva.sv
// Port assertions for the system calibration sequencer.
`timescale 1ns/100ps
module scs_top_sva #(
	parameter int MOD_DIV = 128
) (
	input wire logic                  clk,
	input wire logic                  rst_n,
	input wire scs_pkg::scs_bus_req_t bus_req,
	input wire logic [31:0]           rd_data,
	input wire scs_pkg::scs_sample_t  sample_in,
	input wire logic [2:0]            gain_sel,
	input wire logic                  bipolar,
	input wire logic                  data_ready_n,
	input wire logic                  irq
);
	localparam int RISE_MAX = MOD_DIV + 2;
	logic cmd;
	logic ctl_wr;
	logic busy;
	logic ready_q;
	logic idle_now;
	assign ctl_wr = bus_req.wr && bus_req.addr == 4'h0;
	assign cmd = ctl_wr && bus_req.wdata[1];
	// A step runs from an accepted command to the fall of the ready line.
	assign idle_now = !busy || (ready_q && !data_ready_n);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
			ready_q <= 1'b1;
		end else begin
			ready_q <= data_ready_n;
			busy <= cmd ? 1'b1 : (busy && !idle_now);
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_cal_ready_high: assert property (
		cmd && idle_now && data_ready_n |=> data_ready_n [*8])
		else $error("ready fell right after a step start");
	a_ready_rise_bound: assert property (
		cmd && !data_ready_n |-> ##[1:RISE_MAX] data_ready_n)
		else $error("ready did not rise within one modulator cycle");
	a_idle_rd_zero: assert property (
		!bus_req.rd |=> rd_data == 32'h0000_0000)
		else $error("read data not zero outside the answer cycle");
	a_unmapped_rd_zero: assert property (
		bus_req.rd && bus_req.addr > 4'h7 |=> rd_data == 32'h0000_0000)
		else $error("unmapped read returned data");
	a_gain_held_cal: assert property (
		cmd |=> ##1 ($stable(gain_sel) && $stable(bipolar)) [*7])
		else $error("gain or polarity changed during a step");
	a_data_read_clear: assert property (
		bus_req.rd && bus_req.addr == 4'h7 && !sample_in.valid
		&& !data_ready_n |=> data_ready_n)
		else $error("data read did not raise ready");
	a_irq_masked: assert property (
		bus_req.wr && bus_req.addr == 4'h4 && bus_req.wdata[2:0] == 3'h0
		|=> !irq)
		else $error("interrupt high with all events masked");
	a_ctrl_fields: assert property (
		ctl_wr && idle_now |=> gain_sel == $past(bus_req.wdata[6:4])
		&& bipolar == $past(bus_req.wdata[2]))
		else $error("gain or polarity not taken from control write");
	a_ctrl_refused: assert property (
		ctl_wr && !idle_now |=> $stable(gain_sel) && $stable(bipolar))
		else $error("control write during a step changed gain or polarity");
endmodule

bind scs_top scs_top_sva #(.MOD_DIV(MOD_DIV)) u_sva (.clk(clk), .rst_n(rst_n),
	.bus_req(bus_req), .rd_data(rd_data), .sample_in(sample_in),
	.gain_sel(gain_sel), .bipolar(bipolar), .data_ready_n(data_ready_n),
	.irq(irq));

// file: tb/scs_sample_src.sv
// Converter result source feeding the sequencer.
`timescale 1ns/100ps
module scs_sample_src (
	input wire logic             clk,
	input wire logic             rst_n,
	input wire logic             go,
	input wire logic [31:0]      level,
	output scs_pkg::scs_sample_t smp
);
	// steady applied level
	// The result follows the level the bench holds for the whole step.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			smp <= '0;
		end else begin
			smp.sample <= level;
			smp.valid <= go;
		end
	end
endmodule

// file: tb/scs_top_tb_top.sv
// Self-checking bench for the system calibration sequencer.
`timescale 1ns/100ps
`include "scs_params.svh"
module scs_top_tb_top;
	localparam int MD = 8;
	localparam int P = MD;
	logic                  clk;
	logic                  rst_n;
	logic                  go;
	logic [31:0]           level;
	logic [31:0]           rd_data;
	scs_pkg::scs_bus_req_t req;
	scs_pkg::scs_sample_t  smp;
	logic [2:0]            gain_sel;
	logic                  bipolar;
	logic                  data_ready_n;
	logic                  irq;
	int                    n_errors;
	int                    tests_run;
	int                    cyc;
	int                    t0;
	int                    t_fall;

	scs_top #(.MOD_DIV(MD)) dut (.clk(clk), .rst_n(rst_n), .bus_req(req),
		.rd_data(rd_data), .sample_in(smp), .gain_sel(gain_sel),
		.bipolar(bipolar), .data_ready_n(data_ready_n), .irq(irq));
	scs_sample_src src (.clk(clk), .rst_n(rst_n), .go(go), .level(level),
		.smp(smp));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;
	always @(negedge data_ready_n) t_fall = cyc;

	task automatic end_of_test;
		if (n_errors == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clk);
		req.wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] e,
		input logic [31:0] m);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clk);
		req.rd <= 1'b0;
		#1 chk(rd_data & m, e);
		@(posedge clk);
	endtask

	task automatic wait_low;
		int n;
		n = 0;
		while (data_ready_n !== 1'b0 && n < 200) begin
			@(posedge clk);
			n++;
		end
	endtask

	// One step: ctl command, level held, own and other coefficient.
	task automatic cal_step(input logic [31:0] ctl, input logic [31:0] lv,
		input logic [3:0] ca, input logic [3:0] oa, input logic [31:0] ov,
		input int s);
		level <= lv;
		@(posedge clk);
		wr(`SCS_ADDR_CTRL, ctl);
		t0 = cyc;
		repeat (2 * P) @(posedge clk);
		rd(`SCS_ADDR_CTRL, ctl & 32'h0000_0003, 32'h0000_0003);
		while (cyc - t0 < 3 * P + 3 + s) @(posedge clk);
		rd(`SCS_ADDR_CTRL, 32'h0000_0000, 32'h0000_0003);
		wait_low();
		chk(32'(t_fall - t0 >= 4 * P - 2 && t_fall - t0 <= 4 * P + 3 + s), 1);
		rd(ca, lv, 32'hFFFF_FFFF);
		rd(oa, ov, 32'hFFFF_FFFF);
		chk(32'(gain_sel), 32'(ctl[6:4]));
	endtask

	initial begin
		req = '0;
		go = 1'b0;
		level = 32'h0000_0000;
		rst_n = 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(`SCS_ADDR_ZS_COEF, `SCS_ZS_COEF_RESET, 32'hFFFF_FFFF);
		rd(`SCS_ADDR_FS_COEF, `SCS_FS_COEF_RESET, 32'hFFFF_FFFF);
		rd(`SCS_ADDR_FILTER, 32'(`SCS_FILTER_RESET), 32'h0000_FFFF);
		rd(4'h9, 32'h0000_0000, 32'hFFFF_FFFF);
		chk(32'(data_ready_n), 1);
		rd(`SCS_ADDR_STATUS, 32'h0000_0000, 32'h0000_001F);
		wr(`SCS_ADDR_FILTER, 32'h0000_0001);
		wr(`SCS_ADDR_FILTER, 32'h0000_0000);
		rd(`SCS_ADDR_FILTER, 32'h0000_0001, 32'h0000_FFFF);
		wr(`SCS_ADDR_IRQ_MASK, 32'h0000_0007);
		rd(`SCS_ADDR_IRQ_MASK, 32'h0000_0007, 32'h0000_0007);
		cal_step(32'h0000_0052, 32'h0000_1111, `SCS_ADDR_ZS_COEF,
			`SCS_ADDR_FS_COEF, `SCS_FS_COEF_RESET, 0);
		chk(32'(irq), 1);
		rd(`SCS_ADDR_IRQ_STAT, 32'h0000_0003, 32'h0000_0007);
		chk(32'(irq), 0);
		cal_step(32'h0000_0017, 32'h0070_0000, `SCS_ADDR_FS_COEF,
			`SCS_ADDR_ZS_COEF, 32'h0000_1111, MD);
		chk(32'(bipolar), 1);
		rd(`SCS_ADDR_DATA, 32'h0070_0000, 32'hFFFF_FFFF);
		chk(32'(data_ready_n), 1);
		cal_step(32'h0000_0052, 32'h0000_2222, `SCS_ADDR_ZS_COEF,
			`SCS_ADDR_FS_COEF, 32'h0070_0000, 0);
		wr(`SCS_ADDR_CTRL, 32'h0000_0002);
		wr(`SCS_ADDR_CTRL, 32'h0000_0073);
		repeat (MD + 2) @(posedge clk);
		chk(32'(gain_sel), 32'h0000_0000);
		wait_low();
		rd(`SCS_ADDR_IRQ_STAT, 32'h0000_0004, 32'h0000_0004);
		rd(`SCS_ADDR_FS_COEF, 32'h0070_0000, 32'hFFFF_FFFF);
		wr(`SCS_ADDR_IRQ_MASK, 32'h0000_0000);
		rd(`SCS_ADDR_DATA, 32'h0000_2222, 32'hFFFF_FFFF);
		level <= 32'h0000_3333;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (3) @(posedge clk);
		chk(32'(irq), 0);
		rd(`SCS_ADDR_DATA, 32'h0000_3333, 32'hFFFF_FFFF);
		end_of_test();
	end

	initial begin
		#(3000 * 100);
		n_errors++;
		end_of_test();
	end
endmodule
